// ==== bench/gfm_host.sv ====
`timescale 1ns/10ps
module gfm_host (
  output logic link_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // link clock runs only inside a frame, 32 ns period, stands low between
  task automatic frame(input logic [31:0] cmd, output logic [31:0] rsp);
    cs_n = 1'b0;
    #16;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #16;
      rsp[i] = miso;
      link_clk = 1'b1;
      #16;
      link_clk = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    // released line shows a changing level, not the last bit
    mosi = ~mosi;
  endtask
endmodule

// ==== bench/gyro_fault_monitor_bench.sv ====
`timescale 1ns/10ps
module gyro_fault_monitor_bench;
  import gfm_pkg::*;
  localparam logic [31:0] SEN = 32'h2000_0000;
  localparam logic [31:0] INJ = 32'h2000_0002;
  localparam logic [31:0] RD = 32'h0000_0000;
  logic mclk = 1'b0;
  logic arst_n, link_clk, cs_n, mosi, miso, miso_oe, inject_active;
  logic quad_acc_limit, pll_unlock, amp_low, mem_upset;
  logic [11:0] vreg_mv;
  logic [15:0] quad_val, st_dev, nvm_sum;
  logic [17:0] rate_in;
  logic [31:0] r;
  gfm_flt_t flags;
  int err_count = 0;
  int n_tests = 0;
  logic [10:0] fx [10] = '{11'h104, 11'h084, 11'h020, 11'h020, 11'h020, 11'h002, 11'h002,
    11'h200, 11'h010, 11'h000};
  logic [17:0] rt [5] = '{18'h1FFFF, 18'h20000, 18'h00050, 18'h3FFB0, 18'h08000};
  logic [15:0] rx [5] = '{16'h7FFF, 16'h8000, 16'h0050, 16'hFFB0, 16'h7FFF};

  always #50 mclk = ~mclk;

  gfm_top #(.DECAY_CYC(200)) u_dut (.mclk(mclk), .arst_n(arst_n), .link_clk(link_clk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .vreg_mv(vreg_mv),
    .quad_val(quad_val), .quad_acc_limit(quad_acc_limit), .pll_unlock(pll_unlock),
    .amp_low(amp_low), .st_dev(st_dev), .nvm_sum(nvm_sum), .mem_upset(mem_upset),
    .rate_in(rate_in), .flags(flags), .inject_active(inject_active));
  gfm_host u_host (.link_clk(link_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // answer seen here belongs to the previous frame
  task automatic snd(input logic [31:0] cmd);
    u_host.frame(cmd, r);
    cyc(8);
  endtask
  task automatic ans(input logic [1:0] c, input logic [15:0] d, input logic [7:0] lo);
    chk(r, {c, d, lo, 6'h00});
  endtask
  task automatic cond(input int k, input logic on);
    case (k)
      0: vreg_mv = on ? 12'hCE5 : 12'hBB8;
      1: vreg_mv = on ? 12'hAD1 : 12'hBB8;
      2: quad_val = on ? 16'h1001 : 16'h0000;
      3: quad_val = on ? 16'hEFFF : 16'h0000;
      4: quad_acc_limit = on;
      5: st_dev = on ? 16'h0201 : 16'h0000;
      6: st_dev = on ? 16'hFDFF : 16'h0000;
      7: amp_low = on;
      8: nvm_sum = on ? 16'h0000 : 16'h5A3C;
      default: begin
        vreg_mv = on ? 12'hCE4 : 12'hBB8;
        quad_val = on ? 16'h1000 : 16'h0000;
        st_dev = on ? 16'h0200 : 16'h0000;
      end
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #5000000;
    err_count++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    {quad_acc_limit, pll_unlock, amp_low, mem_upset} = 4'h0;
    vreg_mv = 12'hBB8;
    quad_val = 16'h0000;
    st_dev = 16'h0000;
    nvm_sum = 16'h5A3C;
    rate_in = 18'h00000;
    cyc(4);
    arst_n = 1'b1;
    cyc(4);
    chk(miso_oe, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rate_in = rt[i];
      snd(SEN);
      snd(SEN);
      ans(2'h1, rx[i], 8'h00);
    end
    rate_in = 18'h00000;
    for (int k = 0; k < 10; k++) begin
      cond(k, 1'b1);
      cyc(600);
      cond(k, 1'b0);
      cyc(4);
      chk(flags, fx[k]);
      snd(RD);
      snd(RD);
      chk(r[31:14], {2'h3, 4'h0, fx[k], 1'b0});
      chk(flags, 11'h000);
    end
    // short spike must be filtered out
    vreg_mv = 12'hCE5;
    cyc(3);
    vreg_mv = 12'hBB8;
    cyc(10);
    chk(flags, 11'h000);
    pll_unlock = 1'b1;
    snd(SEN);
    snd(SEN);
    ans(2'h0, 16'h0000, 8'h80);
    chk(flags, 11'h440);
    snd(RD);
    chk(flags, 11'h040);
    pll_unlock = 1'b0;
    snd(RD);
    st_dev = 16'h0741;
    snd(SEN);
    snd(SEN);
    ans(2'h0, 16'h0000, 8'h04);
    st_dev = 16'h0740;
    snd(SEN);
    snd(SEN);
    ans(2'h1, 16'h0000, 8'h04);
    st_dev = 16'h0000;
    snd(RD);
    amp_low = 1'b1;
    snd(SEN);
    snd(SEN);
    ans(2'h1, 16'h0000, 8'h04);
    amp_low = 1'b0;
    snd(RD);
    snd(INJ);
    snd(INJ);
    chk(r[31:14], {2'h1, 16'h0000});
    snd(INJ);
    chk(r[31:30], 2'h2);
    chk(flags & 11'h3FF, 11'h3FF);
    snd(SEN);
    snd(SEN);
    snd(SEN);
    chk(r[31:30], 2'h0);
    chk(inject_active, 1'b1);
    cyc(250);
    chk(inject_active, 1'b0);
    snd(RD);
    snd(SEN);
    snd(SEN);
    ans(2'h1, 16'h0000, 8'h00);
    // one upset only: an even count would flip the copy back
    mem_upset = 1'b1;
    cyc(1);
    mem_upset = 1'b0;
    cyc(12);
    chk(flags, 11'h008);
    // only a fresh reset reloads the volatile copy
    arst_n = 1'b0;
    cyc(4);
    arst_n = 1'b1;
    cyc(40);
    chk(flags, 11'h000);
    final_report();
  end
endmodule

// ==== rtl/gfm_defines.svh ====
// Functional notes
// RQ1: gross fault flag set whenever invalid code forced
// RQ2: sensor reply carries OR of amplitude, self-test
// RQ3: filtered regulator above 3.3 V raises high, supply
// RQ4: filtered regulator below 2.77 V raises low, supply
// RQ5: supply fault follows high or low, glitch filtered
// RQ6: controller reads both flag registers after supply fault
// RQ7: phase-lock fault forces invalid response code
// RQ8: quadrature magnitude above 4096 raises quadrature fault
// RQ9: correction accumulator limit raises quadrature fault
// RQ10: memory checksum every 50 us, mismatch flags
// RQ11: startup copy compared every 1 us, mismatch flags
// RQ12: self-test beyond 512 flags, beyond 1856 invalid
// RQ13: injection provokes all faults within 50 ms
// RQ14: injection active reports self-test response code
// RQ15: faults decay 50 ms after injection cleared
// RQ16: injection results appear one exchange later
// RQ17: data during decay reported as error data
// RQ18: controller budgets about 200 ms for check
// RQ19: rate sent as 16 bits, MSB first
// RQ20: rate two's complement, saturates at extremes
// RQ21: flags sticky until read, re-set if persisting
// RQ22: codes: 00 invalid, 01 valid, 10 test, 11 rw
// RQ23: lower flags appended to every sensor reply
// RQ24: controller holds injection full interval before reading
`ifndef GFM_DEFINES_SVH
`define GFM_DEFINES_SVH
`define GFM_CLK_HZ 10000000
`define GFM_NVM_PERIOD_US 50
`define GFM_NVM_CYC ((`GFM_NVM_PERIOD_US * `GFM_CLK_HZ) / 1000000)
`define GFM_POR_PERIOD_US 1
`define GFM_POR_CYC ((`GFM_POR_PERIOD_US * `GFM_CLK_HZ) / 1000000)
`define GFM_DECAY_MS 50
`define GFM_DECAY_CYC ((`GFM_DECAY_MS * `GFM_CLK_HZ) / 1000)
`define GFM_OV_MV 12'hCE4
`define GFM_UV_MV 12'hAD2
`define GFM_QUAD_LIM 16'h1000
`define GFM_ST_LIM 16'h0200
`define GFM_ST_BIG 16'h0740
`define GFM_RATE_MAX 16'h7FFF
`define GFM_RATE_MIN 16'h8000
`define GFM_FILT_N 4
`define GFM_CODE_INVALID 2'h0
`define GFM_CODE_VALID 2'h1
`define GFM_CODE_TEST 2'h2
`define GFM_CODE_RW 2'h3
`define GFM_FRAME_BITS 6'h20
`define GFM_CMD_SENSOR_BIT 29
`define GFM_CMD_INJ_BIT 1
`define GFM_POR_PATTERN 16'hA5C3
`define GFM_NVM_REF 16'h5A3C
`endif

// ==== rtl/gfm_pkg.sv ====
package gfm_pkg;
  typedef struct packed {
    logic fail;
    logic resonator_level_fault;
    logic ov;
    logic uv;
    logic pll;
    logic q;
    logic rom_checksum_fault;
    logic por;
    logic supply_range_fault;
    logic selftest;
    logic chk;
  } gfm_flt_t;
  typedef struct packed {
    logic [1:0] code;
    logic [15:0] data;
    logic [7:0] lower;
    logic [5:0] pad;
  } gfm_resp_t;
  typedef enum logic [1:0] {GFM_IDLE, GFM_ACTIVE, GFM_DECAY} gfm_inj_t;
endpackage

// ==== rtl/gfm_sync.sv ====
`timescale 1ns/10ps
module gfm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      q <= '1;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

// ==== rtl/gfm_top.sv ====
`timescale 1ns/10ps
`include "gfm_defines.svh"
module gfm_top
  import gfm_pkg::*;
#(
  parameter int DECAY_CYC = `GFM_DECAY_CYC,
  parameter logic [15:0] POR_PATTERN = `GFM_POR_PATTERN,
  parameter logic [15:0] NVM_REF = `GFM_NVM_REF
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [11:0] vreg_mv,
  input wire logic [15:0] quad_val,
  input wire logic quad_acc_limit,
  input wire logic pll_unlock,
  input wire logic amp_low,
  input wire logic [15:0] st_dev,
  input wire logic [15:0] nvm_sum,
  input wire logic mem_upset,
  input wire logic [17:0] rate_in,
  output gfm_flt_t flags,
  output logic inject_active
);
  ////////////////////////////////////////////////////////////////
  // link domain: frame shifter; only its bit counter is cleared by the frame's own select
  logic lrst_n;
  logic [5:0] lcnt_q, lcnt_d;
  logic [31:0] rx_q, rx_d;
  logic len_ok_q, len_ok_d;
  gfm_resp_t resp_q, resp_d;
  logic [31:0] resp_w;

  assign lrst_n = arst_n & ~cs_n;
  assign resp_w = resp_q;

  always_comb begin
    lcnt_d = (lcnt_q == 6'h3F) ? lcnt_q : lcnt_q + 6'h01;
    rx_d = {rx_q[30:0], mosi};
    len_ok_d = (lcnt_q == (`GFM_FRAME_BITS - 6'h01));
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lcnt_q <= 6'h00;
    end else begin
      lcnt_q <= lcnt_d;
    end
  end

  // word and length kept past the frame for the core to pick up
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q <= 32'h0;
      len_ok_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      len_ok_q <= len_ok_d;
    end
  end

  // response word is frozen by the core while the frame runs
  assign miso = lcnt_q[5] ? 1'b0 : resp_w[5'h1F - lcnt_q[4:0]]; // [RQ19]
  assign miso_oe = ~cs_n;

  ////////////////////////////////////////////////////////////////
  // core domain: frame end detect
  logic cs_s;
  logic cs_prev_q;
  logic take;
  logic is_sensor;

  gfm_sync #(.W(1)) u_cs_sync (
    .clk(mclk),
    .rst_n(arst_n),
    .d(cs_n),
    .q(cs_s)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
    end
  end

  // link clock stands still once select is high, so rx is stable here
  assign take = cs_s & ~cs_prev_q & len_ok_q;
  assign is_sensor = rx_q[`GFM_CMD_SENSOR_BIT];

  ////////////////////////////////////////////////////////////////
  // injection sequencer
  gfm_inj_t inj_q, inj_d;
  logic chk_q, chk_d;
  logic [19:0] dcnt_q, dcnt_d;
  logic forced;

  always_comb begin
    chk_d = chk_q;
    if (take && is_sensor) begin
      chk_d = rx_q[`GFM_CMD_INJ_BIT];
    end
    inj_d = inj_q;
    dcnt_d = dcnt_q;
    case (inj_q)
      GFM_IDLE: begin
        if (chk_q) begin
          inj_d = GFM_ACTIVE;
        end
      end
      GFM_ACTIVE: begin
        if (!chk_q) begin
          inj_d = GFM_DECAY; // [RQ15]
          dcnt_d = 20'h0;
        end
      end
      GFM_DECAY: begin
        if (chk_q) begin
          inj_d = GFM_ACTIVE;
        end else if (dcnt_q == 20'(DECAY_CYC - 1)) begin
          inj_d = GFM_IDLE;
        end else begin
          dcnt_d = dcnt_q + 20'h1;
        end
      end
      default: inj_d = GFM_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chk_q <= 1'b0;
      inj_q <= GFM_IDLE;
      dcnt_q <= 20'h0;
    end else begin
      chk_q <= chk_d;
      inj_q <= inj_d;
      dcnt_q <= dcnt_d;
    end
  end

  // every detector is driven into fault while injecting or decaying
  assign forced = (inj_q != GFM_IDLE); // [RQ13]
  assign inject_active = forced;

  ////////////////////////////////////////////////////////////////
  // detectors
  logic [15:0] quad_abs, st_abs;
  logic ov_raw, uv_raw, ov_set, uv_set;
  logic [2:0] ovc_q, ovc_d, uvc_q, uvc_d;
  logic [9:0] ntm_q, ntm_d;
  logic [3:0] ptm_q, ptm_d;
  logic [15:0] vol_q, vol_d;
  logic por_loaded_q;
  logic st_big, invalid;

  assign quad_abs = quad_val[15] ? 16'(-quad_val) : quad_val;
  assign st_abs = st_dev[15] ? 16'(-st_dev) : st_dev;
  assign ov_raw = (vreg_mv > `GFM_OV_MV);
  assign uv_raw = (vreg_mv < `GFM_UV_MV);
  // short excursions are dropped: N samples in a row needed
  assign ov_set = ov_raw && (ovc_q == 3'(`GFM_FILT_N - 1)); // [RQ3] [RQ5]
  assign uv_set = uv_raw && (uvc_q == 3'(`GFM_FILT_N - 1)); // [RQ4] [RQ5]
  assign st_big = (st_abs > `GFM_ST_BIG) || forced; // [RQ12]
  assign invalid = pll_unlock || st_big || forced; // [RQ7] [RQ17]

  always_comb begin
    ovc_d = ov_raw ? (ov_set ? ovc_q : ovc_q + 3'h1) : 3'h0;
    uvc_d = uv_raw ? (uv_set ? uvc_q : uvc_q + 3'h1) : 3'h0;
    ntm_d = (ntm_q == 10'(`GFM_NVM_CYC - 1)) ? 10'h0 : ntm_q + 10'h1;
    ptm_d = (ptm_q == 4'(`GFM_POR_CYC - 1)) ? 4'h0 : ptm_q + 4'h1;
    // copy loaded once after release; only a reset on arst_n reloads it
    vol_d = por_loaded_q ? (vol_q ^ {15'h0, mem_upset}) : POR_PATTERN; // [RQ11]
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovc_q <= 3'h0;
      uvc_q <= 3'h0;
      ntm_q <= 10'h0;
      ptm_q <= 4'h0;
      vol_q <= 16'h0;
      por_loaded_q <= 1'b0;
    end else begin
      ovc_q <= ovc_d;
      uvc_q <= uvc_d;
      ntm_q <= ntm_d;
      ptm_q <= ptm_d;
      vol_q <= vol_d;
      por_loaded_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky flags: a set in the read cycle wins over the clear
  gfm_flt_t flt_q, flt_d, cond;
  logic rd_clr;

  assign rd_clr = take && !is_sensor;

  always_comb begin
    cond = '0;
    cond.fail = take && is_sensor && invalid && !chk_q; // [RQ1]
    cond.resonator_level_fault = amp_low || forced;
    cond.ov = ov_set || forced;
    cond.uv = uv_set || forced;
    cond.pll = pll_unlock || forced;
    cond.q = (quad_abs > `GFM_QUAD_LIM) || quad_acc_limit || forced; // [RQ8] [RQ9]
    cond.rom_checksum_fault = ((ntm_q == 10'h0) && (nvm_sum != NVM_REF)) || forced; // [RQ10]
    cond.por = ((ptm_q == 4'h0) && por_loaded_q && (vol_q != POR_PATTERN)) || forced;
    cond.supply_range_fault = ov_set || uv_set || forced; // [RQ5]
    cond.selftest = (st_abs > `GFM_ST_LIM) || forced; // [RQ12]
    cond.chk = chk_q;
    flt_d = cond | (flt_q & {11{~rd_clr}}); // [RQ21]
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flt_q <= '0;
    end else begin
      flt_q <= flt_d;
    end
  end

  assign flags = flt_q;

  ////////////////////////////////////////////////////////////////
  // response build, loaded only at frame end and frozen after it
  logic [15:0] rate_sat;
  logic [7:0] lower;
  logic [1:0] code;

  always_comb begin
    if (!rate_in[17] && (rate_in[16:15] != 2'b00)) begin
      rate_sat = `GFM_RATE_MAX; // [RQ20]
    end else if (rate_in[17] && (rate_in[16:15] != 2'b11)) begin
      rate_sat = `GFM_RATE_MIN; // [RQ20]
    end else begin
      rate_sat = rate_in[15:0];
    end
  end

  // state sampled before this frame's injection bit lands: [RQ16]
  assign lower = {flt_q.pll, flt_q.q, flt_q.rom_checksum_fault, flt_q.por, flt_q.supply_range_fault,
                  flt_q.selftest | flt_q.resonator_level_fault, flt_q.chk, 1'b0}; // [RQ2] [RQ23]

  always_comb begin
    if (inj_q == GFM_ACTIVE) begin
      code = `GFM_CODE_TEST; // [RQ14] [RQ22]
    end else if (invalid) begin
      code = `GFM_CODE_INVALID; // [RQ7] [RQ17] [RQ22]
    end else begin
      code = `GFM_CODE_VALID; // [RQ22]
    end
    resp_d = resp_q;
    if (take && is_sensor) begin
      resp_d = '{code: code, data: rate_sat, lower: lower, pad: 6'h0};
    end else if (take) begin
      resp_d = '{code: `GFM_CODE_RW,
                 data: {4'h0, flt_q.fail, flt_q.resonator_level_fault, flt_q.ov, flt_q.uv,
                        flt_q.pll, flt_q.q, flt_q.rom_checksum_fault, flt_q.por, flt_q.supply_range_fault,
                        flt_q.selftest, flt_q.chk, 1'b0},
                 lower: lower, pad: 6'h0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  AST_PWR_WITH_OV: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ3]
    ov_set |=> flt_q.ov && flt_q.supply_range_fault) else $error("ov without supply fault");
  AST_UV_FILTER: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ4]
    (!uv_raw ##1 uv_raw [*3]) |-> !uv_set) else $error("low fault set too early");
  AST_PWR_NEEDS_CAUSE: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ5]
    $rose(flt_q.supply_range_fault) |-> $past(ov_set || uv_set || forced))
    else $error("supply fault without cause");
  AST_QUAD_LIMIT: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ8]
    (quad_abs > 16'h1000) |=> flt_q.q) else $error("quadrature not flagged");
  AST_NVM_CHECK: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ10]
    (ntm_q == 10'h0 && nvm_sum != NVM_REF) |=> flt_q.rom_checksum_fault) else $error("nvm not flagged");
  // period checked step by step on the timer instead of one long delay
  AST_NVM_PERIOD: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ10]
    (ntm_q == 10'(`GFM_NVM_CYC - 1)) |=> (ntm_q == 10'h0))
    else $error("checksum period wrong");
  AST_NVM_STEP: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ10]
    (ntm_q != 10'(`GFM_NVM_CYC - 1)) |=> (ntm_q == $past(ntm_q) + 10'h1))
    else $error("checksum timer skipped a step");
  AST_PLL_INVALID: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ7]
    (take && is_sensor && pll_unlock && inj_q != GFM_ACTIVE) |=> resp_q.code == 2'h0)
    else $error("pll fault not marked invalid");
  AST_INJ_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ14]
    (take && is_sensor && inj_q == GFM_ACTIVE) |=> resp_q.code == 2'h2)
    else $error("injection code missing");
  AST_INJ_FLAGS: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ13]
    (inj_q == GFM_ACTIVE) |=> flt_q.ov && flt_q.uv && flt_q.rom_checksum_fault && flt_q.selftest)
    else $error("injected faults missing");
  AST_SELFTEST_OR: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ2]
    (take && is_sensor) |=> resp_q.lower[2] == $past(flt_q.selftest | flt_q.resonator_level_fault))
    else $error("self-test position wrong");
  AST_STICKY: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ21]
    (flt_q.rom_checksum_fault && !rd_clr) |=> flt_q.rom_checksum_fault) else $error("flag dropped without read");
  AST_SAT_POS: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ20]
    (!rate_in[17] && rate_in[16]) |-> rate_sat == 16'h7FFF) else $error("no saturation");
  AST_DECAY_START: assert property (@(posedge mclk) disable iff (!arst_n) // [RQ15]
    (inj_q == GFM_ACTIVE && !chk_q) |=> inj_q == GFM_DECAY && forced)
    else $error("decay not entered");
  COV_SENSOR: cover property (@(posedge mclk) disable iff (!arst_n) take && is_sensor);
  COV_READ: cover property (@(posedge mclk) disable iff (!arst_n) rd_clr && flt_q.supply_range_fault);
  COV_DECAY: cover property (@(posedge mclk) disable iff (!arst_n)
    inj_q == GFM_DECAY ##1 inj_q == GFM_IDLE);
endmodule
